// ### core/tcc_core.sv
// thermocouple conversion core: conversion control, cold-junction path,
// compensation, linearization, result and fault registers
// assumes the serial framer drives the byte register port on clk and holds
// xfer high for the whole of a multibyte transfer
//
// How it works
// - cfg0 bit 7 selects continuous conversions or normally off
// - in normally off, cfg0 bit 6 requests one single conversion
// - cfg1 bits 2:0 pick one of eight types, compensated and linearized
// - raw type settings select gain 8 or 32 and pass the code unchanged
// - internal sensor on: cold-junction bytes read-only, measured plus offset
// - reading cold-junction bytes with internal sensor on sets ready high
// - both cold-junction bytes in one transfer come from one update
// - internal sensor off: bytes writable, hold last value, writes used
// - measured cold-junction value plus offset clamps to 127.984375 C maximum and -64 C minimum; external writes are not clamped
// - offset is signed 8 bits, 0.0625 C per step, resets to zero
// - cfg0 bit 3 disables the internal sensor and allows external writes
// - cold-junction word: two's complement, bit 2 is 1/64 C, bits 1:0 zero
// - cold-junction temperature becomes an interpolated code added to the thermocouple code
// - each conversion stores a 19-bit result, linearized unless raw, in three bytes
// - all three result bytes in one transfer come from one update
// - result word is 24-bit two's complement, bit 8 is 0.0625 C
// - temperature thresholds share the result format
// - cold-junction value compared to its limits, fault bits set on excess
// - an unmasked set threshold fault drives the fault output active
// - four threshold bytes limit the result and set fault bits
`timescale 1ns/1ps
module tcc_core
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port from the serial framer
  input wire tcc_bus_s bus,
  output logic [7:0] rdata,
  // analog front end
  output logic conv_start,
  output logic gain_32,
  input wire tcc_adc_s adc,
  input wire tcc_cj_s cj_sense,
  // fault masking, one bit per threshold fault, high masks
  input wire logic [3:0] fault_mask,
  // pins
  output logic result_ready_out_n,
  output logic fault_n
);

  tcc_state_s s_q, s_d;

  // clamp a widened cold-junction sum, keep bits 1:0 zero
  function automatic logic [15:0] cj_clamp(input logic signed [16:0] v);
    logic signed [16:0] hi;
    logic signed [16:0] lo;
    hi = {CJ_MAX[15], CJ_MAX};
    lo = {CJ_MIN[15], CJ_MIN};
    if (v > hi) begin
      cj_clamp = CJ_MAX;
    end else if (v < lo) begin
      cj_clamp = CJ_MIN;
    end else begin
      cj_clamp = {v[15:2], 2'b00};
    end
  endfunction

  // cold-junction word to equivalent adc code, piecewise between table points
  function automatic logic [19:0] cj_to_code(input logic [15:0] cj,
                                              input logic [2:0] typ);
    logic signed [16:0] slope;
    logic signed [33:0] prod;
    slope = cj[15] ? $signed({1'b0, SLOPE_NEG[typ]}) : $signed({1'b0, SLOPE_POS[typ]});
    prod = $signed(cj) * slope;
    prod = prod >>> CJ_SLOPE_SHIFT;
    cj_to_code = prod[19:0];
  endfunction

  // compensated code to temperature in 1/128 C steps
  function automatic logic [18:0] linearize(input logic [19:0] comp,
                                             input logic [2:0] typ);
    logic signed [16:0] inv;
    logic signed [37:0] prod;
    inv = $signed({1'b0, INV_SENS[typ]});
    prod = $signed(comp) * inv;
    prod = prod >>> LIN_SHIFT;
    linearize = prod[18:0];
  endfunction

  logic raw_mode;
  logic ext_cj;
  logic [2:0] tc_type;
  logic signed [16:0] cj_sum;
  logic [19:0] cj_code;
  logic [15:0] res_hi16;
  logic cj_over;
  logic cj_under;
  logic tc_over;
  logic tc_under;
  logic [3:0] flt_raw;

  assign raw_mode = s_q.cfg1[CFG1_RAW];
  assign tc_type = s_q.cfg1[2:0];
  assign ext_cj = s_q.cfg0[CFG0_EXT_CJ];
  // offset lsb of 1/16 C sits four places up in the 1/256 C word
  assign cj_sum = $signed({cj_sense.temp[15], cj_sense.temp})
                  + ($signed({{5{s_q.cj_off[7]}}, s_q.cj_off, 4'h0}));
  assign cj_code = cj_to_code(s_q.cj, tc_type);
  assign res_hi16 = s_q.lin[23:8];
  assign cj_over = $signed(s_q.cj[15:8]) > $signed(s_q.cj_hi_lim);
  assign cj_under = $signed(s_q.cj[15:8]) < $signed(s_q.cj_lo_lim);
  assign tc_over = $signed(res_hi16) > $signed(s_q.tc_hi);
  assign tc_under = $signed(res_hi16) < $signed(s_q.tc_lo);
  assign flt_raw = {s_q.fault[FLT_CJ_HI], s_q.fault[FLT_CJ_LO],
                    s_q.fault[FLT_TC_HI], s_q.fault[FLT_TC_LO]};

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;

    // register writes
    if (bus.we) begin
      case (bus.addr)
        A_CFG0: s_d.cfg0 = bus.wdata;
        A_CFG1: s_d.cfg1 = bus.wdata;
        A_CJ_HI_LIM: s_d.cj_hi_lim = bus.wdata;
        A_CJ_LO_LIM: s_d.cj_lo_lim = bus.wdata;
        A_TC_HI_MSB: s_d.tc_hi[15:8] = bus.wdata;
        A_TC_HI_LSB: s_d.tc_hi[7:0] = bus.wdata;
        A_TC_LO_MSB: s_d.tc_lo[15:8] = bus.wdata;
        A_TC_LO_LSB: s_d.tc_lo[7:0] = bus.wdata;
        A_CJ_OFFSET: s_d.cj_off = bus.wdata;
        A_CJ_TEMP_HI: begin
          if (ext_cj) begin
            s_d.cj[15:8] = bus.wdata;
          end
        end
        A_CJ_TEMP_LO: begin
          if (ext_cj) begin
            s_d.cj[7:0] = {bus.wdata[7:2], 2'b00};
          end
        end
        default: begin
        end
      endcase
    end

    // internal sensor updates; when disabled the last value simply stays
    if (!ext_cj && cj_sense.valid) begin
      s_d.cj = cj_clamp(cj_sum);
    end

    // register reads, answer one cycle later from a flop
    if (bus.re) begin
      case (bus.addr)
        A_CFG0: s_d.rdata = s_q.cfg0;
        A_CFG1: s_d.rdata = s_q.cfg1;
        A_CJ_HI_LIM: s_d.rdata = s_q.cj_hi_lim;
        A_CJ_LO_LIM: s_d.rdata = s_q.cj_lo_lim;
        A_TC_HI_MSB: s_d.rdata = s_q.tc_hi[15:8];
        A_TC_HI_LSB: s_d.rdata = s_q.tc_hi[7:0];
        A_TC_LO_MSB: s_d.rdata = s_q.tc_lo[15:8];
        A_TC_LO_LSB: s_d.rdata = s_q.tc_lo[7:0];
        A_CJ_OFFSET: s_d.rdata = s_q.cj_off;
        A_CJ_TEMP_HI: s_d.rdata = s_q.cj_snap[15:8];
        A_CJ_TEMP_LO: s_d.rdata = s_q.cj_snap[7:0];
        A_LIN_B2: s_d.rdata = s_q.lin_snap[23:16];
        A_LIN_B1: s_d.rdata = s_q.lin_snap[15:8];
        A_LIN_B0: s_d.rdata = s_q.lin_snap[7:0];
        A_FAULT: s_d.rdata = s_q.fault;
        default: s_d.rdata = RD_INVALID;
      endcase
      if (!ext_cj && (bus.addr == A_CJ_TEMP_HI || bus.addr == A_CJ_TEMP_LO)) begin
        s_d.ready_n = 1'b1;
      end
    end

    // conversion sequencing
    case (s_q.st)
      ST_IDLE: begin
        if (s_q.cfg0[CFG0_CONT] || s_q.cfg0[CFG0_ONESHOT]) begin
          s_d.start = 1'b1;
          s_d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (adc.valid) begin
          s_d.tc = adc.code;
          s_d.st = ST_CALC;
        end
      end
      ST_CALC: begin
        s_d.comp = $signed({s_q.tc[18], s_q.tc}) + $signed(cj_code);
        s_d.st = ST_STORE;
      end
      ST_STORE: begin
        if (raw_mode) begin
          s_d.lin = {s_q.tc, 5'h00};
        end else begin
          s_d.lin = {linearize(s_q.comp, tc_type), 5'h00};
        end
        s_d.ready_n = 1'b0;
        // a host write of bit 6 in this same cycle still stands after the clear
        if (!(bus.we && bus.addr == A_CFG0)) begin
          s_d.cfg0[CFG0_ONESHOT] = 1'b0;
        end
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase

    // snapshots only move between transfers so a burst reads one update; they take the
    // value stored this edge, so a transfer opened as ready falls already sees the result
    if (!bus.xfer) begin
      s_d.cj_snap = s_d.cj;
      s_d.lin_snap = s_d.lin;
    end

    // threshold faults track the latest compared values
    s_d.fault[FLT_CJ_HI] = cj_over;
    s_d.fault[FLT_CJ_LO] = cj_under;
    s_d.fault[FLT_TC_HI] = tc_over;
    s_d.fault[FLT_TC_LO] = tc_under;
    s_d.fault_n = ~|(flt_raw & ~fault_mask);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.st <= ST_IDLE;
      s_q.cfg0 <= CFG0_RST;
      s_q.cfg1 <= CFG1_RST;
      s_q.cj_hi_lim <= CJ_HI_LIM_RST;
      s_q.cj_lo_lim <= CJ_LO_LIM_RST;
      s_q.tc_hi <= TC_HI_RST;
      s_q.tc_lo <= TC_LO_RST;
      s_q.cj_off <= CJ_OFFSET_RST;
      s_q.cj <= 16'h0000;
      s_q.cj_snap <= 16'h0000;
      s_q.tc <= 19'h00000;
      s_q.comp <= 20'h00000;
      s_q.lin <= 24'h000000;
      s_q.lin_snap <= 24'h000000;
      s_q.fault <= 8'h00;
      s_q.rdata <= 8'h00;
      s_q.start <= 1'b0;
      s_q.ready_n <= 1'b1;
      s_q.fault_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign conv_start = s_q.start;
  assign gain_32 = s_q.cfg1[CFG1_GAIN32];
  assign result_ready_out_n = s_q.ready_n;
  assign fault_n = s_q.fault_n;

endmodule

// ### core/tcc_pkg.sv
// constants, carriers and state types of the thermocouple conversion core
// assumes a single clock domain and a byte-wide register port from the serial framer
package tcc_pkg;

  // register offsets
  localparam logic [7:0] A_CFG0 = 8'h00;
  localparam logic [7:0] A_CFG1 = 8'h01;
  localparam logic [7:0] A_CJ_HI_LIM = 8'h03;
  localparam logic [7:0] A_CJ_LO_LIM = 8'h04;
  localparam logic [7:0] A_TC_HI_MSB = 8'h05;
  localparam logic [7:0] A_TC_HI_LSB = 8'h06;
  localparam logic [7:0] A_TC_LO_MSB = 8'h07;
  localparam logic [7:0] A_TC_LO_LSB = 8'h08;
  localparam logic [7:0] A_CJ_OFFSET = 8'h09;
  localparam logic [7:0] A_CJ_TEMP_HI = 8'h0a;
  localparam logic [7:0] A_CJ_TEMP_LO = 8'h0b;
  localparam logic [7:0] A_LIN_B2 = 8'h0c;
  localparam logic [7:0] A_LIN_B1 = 8'h0d;
  localparam logic [7:0] A_LIN_B0 = 8'h0e;
  localparam logic [7:0] A_FAULT = 8'h0f;
  localparam logic [7:0] RD_INVALID = 8'hff;

  // field positions
  localparam int CFG0_CONT = 7;
  localparam int CFG0_ONESHOT = 6;
  localparam int CFG0_EXT_CJ = 3;
  localparam int CFG1_RAW = 3;
  localparam int CFG1_GAIN32 = 2;
  localparam int FLT_CJ_HI = 5;
  localparam int FLT_CJ_LO = 4;
  localparam int FLT_TC_HI = 3;
  localparam int FLT_TC_LO = 2;

  // reset values
  localparam logic [7:0] CFG0_RST = 8'h00;
  localparam logic [7:0] CFG1_RST = 8'h03;
  localparam logic [7:0] CJ_HI_LIM_RST = 8'h7f;
  localparam logic [7:0] CJ_LO_LIM_RST = 8'hc0;
  localparam logic [15:0] TC_HI_RST = 16'h7fff;
  localparam logic [15:0] TC_LO_RST = 16'h8000;
  localparam logic [7:0] CJ_OFFSET_RST = 8'h00;

  // cold-junction word limits: +127.984375 and -64 degrees
  localparam logic [15:0] CJ_MAX = 16'h7ffc;
  localparam logic [15:0] CJ_MIN = 16'hc000;
  localparam int OFFSET_SHIFT = 4;
  localparam int CJ_SLOPE_SHIFT = 8;
  localparam int LIN_SHIFT = 12;

  // table: codes per degree below and above 0 C, and inverse sensitivity
  localparam logic [15:0] SLOPE_NEG [8] = '{16'h0010, 16'h0060, 16'h0048, 16'h0034,
                                            16'h002c, 16'h0010, 16'h0010, 16'h0040};
  localparam logic [15:0] SLOPE_POS [8] = '{16'h0014, 16'h0078, 16'h005a, 16'h0040,
                                            16'h0038, 16'h0014, 16'h0012, 16'h0050};
  localparam logic [15:0] INV_SENS [8] = '{16'h6000, 16'h0880, 16'h0b40, 16'h1000,
                                           16'h1240, 16'h6000, 16'h6800, 16'h0c80};

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_CALC = 4'b0100,
    ST_STORE = 4'b1000
  } tcc_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic xfer;
  } tcc_bus_s;

  typedef struct packed {
    logic valid;
    logic [18:0] code;
  } tcc_adc_s;

  typedef struct packed {
    logic valid;
    logic [15:0] temp;
  } tcc_cj_s;

  typedef struct packed {
    tcc_state_e st;
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [7:0] cj_hi_lim;
    logic [7:0] cj_lo_lim;
    logic [15:0] tc_hi;
    logic [15:0] tc_lo;
    logic [7:0] cj_off;
    logic [15:0] cj;
    logic [15:0] cj_snap;
    logic [18:0] tc;
    logic [19:0] comp;
    logic [23:0] lin;
    logic [23:0] lin_snap;
    logic [7:0] fault;
    logic [7:0] rdata;
    logic start;
    logic ready_n;
    logic fault_n;
  } tcc_state_s;

endpackage

// ### tb/tcc_core_sva.sv
// port checker for the conversion core
// assumes one clock domain; bound to every tcc_core instance below
`timescale 1ns/1ps
module tcc_core_sva
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port and front end
  input wire tcc_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic conv_start,
  input wire logic gain_32,
  input wire tcc_adc_s adc,
  input wire tcc_cj_s cj_sense,
  input wire logic [3:0] fault_mask,
  // pins
  input wire logic result_ready_out_n,
  input wire logic fault_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a start is outstanding until the front end answers, possibly in the start cycle itself
  logic pend_q;
  logic outstanding;
  assign outstanding = pend_q || conv_start;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= outstanding && !adc.valid;
    end
  end
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  chk_single_start: assert property (conv_start |-> !pend_q)
    else $error("start while a conversion is outstanding");
  chk_gain_select: assert property (bus.we && bus.addr == A_CFG1 |=>
    gain_32 == $past(bus.wdata[CFG1_GAIN32])) else $error("gain select wrong");
  chk_result_store: assert property (outstanding && adc.valid |->
    ##3 !result_ready_out_n) else $error("result not stored three cycles after data");
  chk_ready_cause: assert property ($fell(result_ready_out_n) |->
    $past(adc.valid, 3)) else $error("ready fell without converter data");
  chk_ready_stands: assert property (!result_ready_out_n && !bus.re |=>
    !result_ready_out_n) else $error("ready released without a read");
  chk_mask_quiet: assert property (fault_mask == 4'hf [*2] |=> fault_n)
    else $error("fault pin active while all sources masked");
  chk_rdata_hold: assert property (!bus.re |=> $stable(rdata))
    else $error("read byte changed without a read");
  cover property (conv_start);
  cover property ($fell(result_ready_out_n));
  cover property ($fell(fault_n));
endmodule

bind tcc_core tcc_core_sva u_sva (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
  .conv_start(conv_start), .gain_32(gain_32), .adc(adc), .cj_sense(cj_sense),
  .fault_mask(fault_mask), .result_ready_out_n(result_ready_out_n), .fault_n(fault_n));

// ### tb/tcc_host_model.sv
// host and analog front-end model of the conversion core
// assumes its tasks are entered 1 ns after a rising clock edge
`timescale 1ns/1ps
module tcc_host_model
  import tcc_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output tcc_bus_s bus,
  input wire logic [7:0] rdata,
  // front end
  input wire logic conv_start,
  output tcc_adc_s adc
);
  int lat = 0;
  logic [18:0] code = '0;
  initial begin
    bus = '0;
    adc = '0;
  end
  // answers each start after lat more edges; released code is inverted
  always begin
    @(posedge clk);
    #1;
    if (conv_start === 1'b1) begin
      repeat (lat) @(posedge clk);
      #1;
      adc.valid = 1'b1;
      adc.code = code;
      @(posedge clk);
      #1;
      adc.valid = 1'b0;
      adc.code = ~code;
    end
  end
  // one byte write inside its own transfer; a gap edge follows
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.xfer = 1'b1;
    @(posedge clk);
    #1;
    bus.addr = a;
    bus.wdata = d;
    bus.we = 1'b1;
    @(posedge clk);
    #1;
    bus.we = 1'b0;
    bus.xfer = 1'b0;
    bus.wdata = ~d;
    @(posedge clk);
    #1;
  endtask
  // n bytes from a onward, all within one transfer
  task automatic rd(input logic [7:0] a, input int n, output logic [23:0] v);
    v = '0;
    bus.xfer = 1'b1;
    @(posedge clk);
    #1;
    for (int i = 0; i < n; i++) begin
      bus.addr = a + 8'(i);
      bus.re = 1'b1;
      @(posedge clk);
      #1;
      v = {v[15:0], rdata};
    end
    bus.re = 1'b0;
    bus.xfer = 1'b0;
    bus.addr = ~bus.addr;
    @(posedge clk);
    #1;
  endtask
endmodule

// ### tb/tcc_core_bench.sv
// self-checking bench of the conversion core
// assumes the checker binds itself and the host model drives the bus
`timescale 1ns/1ps
module tcc_core_bench
  import tcc_pkg::*;
;
  logic clk, reset_n, conv_start, gain_32, result_ready_out_n, fault_n;
  tcc_bus_s bus;
  tcc_adc_s adc;
  tcc_cj_s cjs;
  logic [3:0] fault_mask;
  logic [7:0] rdata, off;
  logic [23:0] v;
  logic [18:0] c;
  logic [15:0] t;
  int failures = 0;
  int checks_done = 0;
  int n_start = 0;
  logic [7:0] ra [10] = '{A_CFG0, A_CFG1, A_CJ_HI_LIM, A_CJ_LO_LIM, A_TC_HI_MSB, A_TC_HI_LSB,
    A_TC_LO_MSB, A_TC_LO_LSB, A_CJ_OFFSET, 8'h10};
  logic [7:0] rv [10] = '{CFG0_RST, CFG1_RST, CJ_HI_LIM_RST, CJ_LO_LIM_RST, TC_HI_RST[15:8],
    TC_HI_RST[7:0], TC_LO_RST[15:8], TC_LO_RST[7:0], CJ_OFFSET_RST, RD_INVALID};
  tcc_core u_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .conv_start(conv_start), .gain_32(gain_32), .adc(adc), .cj_sense(cjs),
    .fault_mask(fault_mask), .result_ready_out_n(result_ready_out_n), .fault_n(fault_n));
  tcc_host_model u_host (.clk(clk), .bus(bus), .rdata(rdata), .conv_start(conv_start),
    .adc(adc));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (conv_start === 1'b1) n_start++;
  end
  // offset steps are 1/16 degree, the word 1/256 degree
  function automatic logic [15:0] exp_cj(input logic [15:0] tt, input logic [7:0] oo);
    int s;
    s = int'($signed(tt)) + 16 * int'($signed(oo));
    if (s > $signed(CJ_MAX)) return CJ_MAX;
    if (s < $signed(CJ_MIN)) return CJ_MIN;
    return 16'(s);
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic sense(input logic [15:0] tt);
    cjs.valid = 1'b1;
    cjs.temp = tt;
    @(posedge clk);
    #1;
    cjs.valid = 1'b0;
    cjs.temp = ~tt;
    @(posedge clk);
    #1;
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 300 && result_ready_out_n !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  initial begin
    reset_n = 1'b0;
    cjs = '0;
    fault_mask = 4'h0;
    void'($urandom(19510));
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    foreach (ra[i]) begin
      u_host.rd(ra[i], 1, v);
      chk(v, {16'h0, rv[i]}, "reset value");
    end
    for (int k = 0; k < 8; k++) begin
      u_host.wr(A_CFG1, 8'(k));
      u_host.rd(A_CFG1, 1, v);
      chk(v, 24'(k), "type readback");
    end
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      c = (k == 0) ? 19'h40000 : 19'($urandom());
      u_host.code = c;
      u_host.lat = k[0] ? 20 : 0;
      u_host.wr(A_CFG1, k[1] ? 8'h0c : 8'h08);
      chk(24'(gain_32), 24'(k[1]), "gain");
      u_host.wr(A_CFG0, 8'h40);
      wait_ready();
      chk(24'(result_ready_out_n), 24'h0, "no one-shot result");
      u_host.rd(A_LIN_B2, 3, v);
      chk(v, {c, 5'h0}, "result bytes");
      u_host.rd(A_CFG0, 1, v);
      chk(v, 24'h0, "one-shot bit kept");
      u_host.rd(A_CJ_TEMP_HI, 2, v);
      chk(24'(result_ready_out_n), 24'h1, "ready not released");
    end
    $display("test one-shot done");
    u_host.wr(A_CFG0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      t = (k == 0) ? 16'h7f00 : (k == 1) ? 16'hc100 : 16'($urandom()) & 16'hfffc;
      off = (k == 0) ? 8'h7f : (k == 1) ? 8'h80 : 8'($urandom());
      u_host.wr(A_CJ_OFFSET, off);
      sense(t);
      u_host.rd(A_CJ_TEMP_HI, 2, v);
      chk(v, {8'h0, exp_cj(t, off)}, "cold junction word");
    end
    u_host.wr(A_CFG0, 8'h08);
    u_host.wr(A_CJ_TEMP_HI, 8'h19);
    u_host.wr(A_CJ_TEMP_LO, 8'h03);
    sense(16'h0000);
    u_host.rd(A_CJ_TEMP_HI, 2, v);
    chk(v, 24'h1900, "external word");
    $display("test cold junction done");
    u_host.wr(A_CJ_HI_LIM, 8'h10);
    repeat (6) @(posedge clk);
    #1;
    chk(24'(fault_n), 24'h0, "fault pin idle");
    u_host.rd(A_FAULT, 1, v);
    chk(v, 24'h20, "high fault flag");
    fault_mask = 4'h8;
    repeat (3) @(posedge clk);
    #1;
    chk(24'(fault_n), 24'h1, "masked fault drives pin");
    u_host.wr(A_CJ_LO_LIM, 8'h1a);
    u_host.rd(A_FAULT, 1, v);
    chk(v, 24'h30, "low fault flag");
    chk(24'(fault_n), 24'h0, "unmasked low fault silent");
    // thresholds at the far ends of the range trip both result faults for the last result unless it sits at that end
    t = c[18:3];
    off = {4'h3, $signed(t) > $signed(16'h8000), $signed(t) < $signed(16'h7fff), 2'b00};
    u_host.wr(A_TC_HI_MSB, 8'h80);
    u_host.wr(A_TC_HI_LSB, 8'h00);
    u_host.wr(A_TC_LO_MSB, 8'h7f);
    u_host.wr(A_TC_LO_LSB, 8'hff);
    u_host.rd(A_FAULT, 1, v);
    chk(v, {16'h0, off}, "result fault flags");
    fault_mask = 4'hf;
    repeat (3) @(posedge clk);
    #1;
    chk(24'(fault_n), 24'h1, "fault pin active while all masked");
    $display("test faults done");
    u_host.wr(A_CFG1, 8'h08);
    u_host.lat = 3;
    n_start = 0;
    u_host.wr(A_CFG0, 8'h80);
    repeat (100) @(posedge clk);
    #1;
    chk(24'(n_start > 5), 24'h1, "continuous starts missing");
    u_host.wr(A_CFG0, 8'h00);
    repeat (20) @(posedge clk);
    n_start = 0;
    repeat (60) @(posedge clk);
    #1;
    chk(24'(n_start), 24'h0, "starts while normally off");
    $display("test continuous done");
    tally_and_finish();
  end
  initial begin
    #100us;
    failures++;
    tally_and_finish();
  end
endmodule
